// ---- include/pra_map.svh ----
// Register offsets, field positions, reset values and timing counts of the phase realign block.
`ifndef PRA_MAP_SVH
`define PRA_MAP_SVH

// Register offsets on the byte-wide configuration port.
`define PRA_OFS_THRESH 8'h2f
`define PRA_OFS_DELAY 8'h30
`define PRA_OFS_ENABLE 8'h31
`define PRA_OFS_STAT_MIS 8'h32
`define PRA_OFS_STAT_HOLD 8'h33

// Field positions in the threshold register.
`define PRA_HOLDOFF_MSB 7
`define PRA_HOLDOFF_LSB 4
`define PRA_TRIP_MSB 3
`define PRA_TRIP_LSB 0

// Field positions in the detect delay and protection register.
`define PRA_RISE_MSB 7
`define PRA_RISE_LSB 5
`define PRA_FALL_MSB 4
`define PRA_FALL_LSB 2
`define PRA_SCP_BIT 1
`define PRA_VOLTAGE_DIFFERENCE_FAULT_CFG_BIT 0

// Field positions in the enable register and the hold-off status register.
`define PRA_ENABLE_BIT 6
`define PRA_STAT_HOLD_OK_BIT 7

// Reset values.
`define PRA_RST_THRESH 8'h00
`define PRA_RST_DELAY 8'h00
`define PRA_RST_ENABLE 8'h00

// Timing: one delay step in ns, the clock period in ps, and the step in clock cycles.
`define PRA_DELAY_STEP_NS 50
`define PRA_CLK_PERIOD_PS 5000
`define PRA_STEP_CYC ((`PRA_DELAY_STEP_NS * 1000) / `PRA_CLK_PERIOD_PS)

`endif

// ---- include/pra_pkg.sv ----
// Types shared by the phase realign block.
`default_nettype none
package pra_pkg;
	typedef logic [7:0] pra_byte_t;
	typedef enum logic {
		DLY_IDLE,
		DLY_COUNT
	} pra_dly_state_t;
endpackage
`default_nettype wire

// ---- logic/pra_det_delay.sv ----
// Programmable delay of a detect event in steps of a fixed number of clock cycles.
`timescale 1ns/1ps
`default_nettype none
module pra_det_delay #(
	parameter int SEL_W = 3,
	parameter int STEP_CYC = 10,
	parameter int CNT_W = 8
) (
	input wire logic clk_sys,
	input wire logic reset,
	input wire logic trig,
	input wire logic [SEL_W-1:0] sel,
	output var logic fire_r
);

	pra_pkg::pra_dly_state_t state_r;
	pra_pkg::pra_dly_state_t state_nxt;
	logic [CNT_W-1:0] cnt_r;
	logic [CNT_W-1:0] cnt_nxt;
	logic fire_nxt;
	wire logic [CNT_W-1:0] load_val = CNT_W'(sel * STEP_CYC);
	wire logic last_tick = (state_r == pra_pkg::DLY_COUNT) && (cnt_r == CNT_W'(1));

	////////////////////////////////////////////////////////////////////////////
	// A new trigger restarts the delay; a zero setting fires on the next cycle.
	always_comb begin
		state_nxt = state_r;
		cnt_nxt = cnt_r;
		fire_nxt = 1'b0;
		if (trig) begin
			if (sel == '0) begin
				fire_nxt = 1'b1;
				state_nxt = pra_pkg::DLY_IDLE;
			end else begin
				cnt_nxt = load_val;
				state_nxt = pra_pkg::DLY_COUNT;
			end
		end else begin
			unique case (state_r)
				pra_pkg::DLY_IDLE: begin
					cnt_nxt = cnt_r;
				end
				pra_pkg::DLY_COUNT: begin
					cnt_nxt = cnt_r - CNT_W'(1);
					if (last_tick) begin
						fire_nxt = 1'b1;
						state_nxt = pra_pkg::DLY_IDLE;
					end
				end
			endcase
		end
	end

	always_ff @(posedge clk_sys or posedge reset) begin
		if (reset) begin
			state_r <= pra_pkg::DLY_IDLE;
			cnt_r <= '0;
			fire_r <= 1'b0;
		end else begin
			state_r <= state_nxt;
			cnt_r <= cnt_nxt;
			fire_r <= fire_nxt;
		end
	end

	////////////////////////////////////////////////////////////////////////////
	default clocking dly_cb @(posedge clk_sys); endclocking
	default disable iff (reset);

	sequence s_last_tick;
		!trig && last_tick;
	endsequence

	sequence s_zero_trig;
		trig && (sel == '0);
	endsequence

	delay_end_fire_a: assert property (s_last_tick |=> fire_r)
		else $error("delayed detect did not fire at the end of its count");
	zero_delay_fire_a: assert property (s_zero_trig |=> fire_r && state_r == pra_pkg::DLY_IDLE)
		else $error("zero delay setting did not fire on the next cycle");
	load_steps_a: assert property (trig && sel != '0 |=> cnt_r == CNT_W'($past(sel) * STEP_CYC))
		else $error("delay count not loaded with setting times step");
	no_early_fire_a: assert property (state_r == pra_pkg::DLY_COUNT && cnt_r > CNT_W'(1) && !trig |=> !fire_r)
		else $error("detect fired before its delay ran out");

endmodule // pra_det_delay
`default_nettype wire

// ---- logic/pra_top.sv ----
// Phase realign supervisor and channel-2 detect delay configuration of the second power stage.
`timescale 1ns/1ps
`default_nettype none
`include "pra_map.svh"
module pra_top #(
	parameter int MIS_W = 5,
	parameter int HOLD_W = 4,
	parameter int DLY_CNT_W = 8
) (
	input wire logic clk_sys,
	input wire logic reset,
	input wire logic [7:0] addr,
	input wire logic [7:0] wdata,
	input wire logic wr_en,
	input wire logic rd_en,
	output wire logic [7:0] rdata,
	input wire logic ch1_period,
	input wire logic s2_period,
	input wire logic s2_id_ok,
	input wire logic ch2_active,
	input wire logic aux_above,
	output wire logic realign_pulse,
	output wire logic ch2_rise_det,
	output wire logic ch2_fall_det,
	output wire logic short_protect_en,
	output wire logic voltage_difference_fault_cfg_fault_en
);

	////////////////////////////////////////////////////////////////////////////
	// Configuration registers.
	pra_pkg::pra_byte_t phase_realign_thresholds_r;
	pra_pkg::pra_byte_t ch2_detect_delay_protect_r;
	logic phase_realign_enable_r;
	pra_pkg::pra_byte_t rdata_r;
	pra_pkg::pra_byte_t rdata_nxt;

	wire logic sel_thresh = (addr == `PRA_OFS_THRESH);
	wire logic sel_delay = (addr == `PRA_OFS_DELAY);
	wire logic sel_enable = (addr == `PRA_OFS_ENABLE);
	wire logic sel_stat_mis = (addr == `PRA_OFS_STAT_MIS);
	wire logic sel_stat_hold = (addr == `PRA_OFS_STAT_HOLD);

	wire logic wr_thresh = wr_en && sel_thresh;
	wire logic wr_delay = wr_en && sel_delay;
	wire logic wr_enable = wr_en && sel_enable;

	wire logic [HOLD_W-1:0] realign_holdoff_count =
		phase_realign_thresholds_r[`PRA_HOLDOFF_MSB:`PRA_HOLDOFF_LSB];
	wire logic [3:0] mismatch_trip_threshold = phase_realign_thresholds_r[`PRA_TRIP_MSB:`PRA_TRIP_LSB];
	wire logic [2:0] ch2_rising_detect_delay = ch2_detect_delay_protect_r[`PRA_RISE_MSB:`PRA_RISE_LSB];
	wire logic [2:0] ch2_falling_detect_delay = ch2_detect_delay_protect_r[`PRA_FALL_MSB:`PRA_FALL_LSB];
	wire logic short_protect_disable = ch2_detect_delay_protect_r[`PRA_SCP_BIT];
	wire logic voltage_difference_fault_cfg = ch2_detect_delay_protect_r[`PRA_VOLTAGE_DIFFERENCE_FAULT_CFG_BIT];

	always_ff @(posedge clk_sys or posedge reset) begin
		if (reset) begin
			phase_realign_thresholds_r <= `PRA_RST_THRESH;
			ch2_detect_delay_protect_r <= `PRA_RST_DELAY;
			phase_realign_enable_r <= 1'(`PRA_RST_ENABLE >> `PRA_ENABLE_BIT);
		end else begin
			if (wr_thresh) begin
				phase_realign_thresholds_r <= wdata;
			end
			if (wr_delay) begin
				ch2_detect_delay_protect_r <= wdata;
			end
			if (wr_enable) begin
				phase_realign_enable_r <= wdata[`PRA_ENABLE_BIT];
			end
		end
	end

	////////////////////////////////////////////////////////////////////////////
	// Realignment supervisor.
	localparam logic [MIS_W-1:0] MIS_MAX = '1;
	localparam logic [HOLD_W-1:0] HOLD_MAX = '1;

	logic [MIS_W-1:0] mismatch_r;
	logic [MIS_W-1:0] mismatch_nxt;
	logic [HOLD_W-1:0] holdoff_r;
	logic [HOLD_W-1:0] holdoff_nxt;
	logic realign_r;

	wire logic wrong_id = s2_period && !s2_id_ok;
	wire logic right_id = s2_period && s2_id_ok;
	wire logic holdoff_ok = (holdoff_r >= realign_holdoff_count);
	wire logic trip_over = (mismatch_r > MIS_W'(mismatch_trip_threshold));
	wire logic realign_go = phase_realign_enable_r && trip_over && holdoff_ok;

	// Realignment wins over a same-cycle step, so a stale period cannot re-arm the trip at once.
	// mismatch up/down, floor and clear
	always_comb begin
		mismatch_nxt = mismatch_r;
		if (realign_go) begin
			mismatch_nxt = '0;
		end else if (wrong_id) begin
			if (mismatch_r != MIS_MAX) begin
				mismatch_nxt = mismatch_r + MIS_W'(1);
			end
		end else if (right_id) begin
			if (mismatch_r >= MIS_W'(2)) begin
				mismatch_nxt = mismatch_r - MIS_W'(2);
			end else begin
				mismatch_nxt = '0;
			end
		end
	end

	// The hold-off count starts saturated so the first realignment is never blocked.
	// hold-off count
	always_comb begin
		holdoff_nxt = holdoff_r;
		if (realign_go) begin
			holdoff_nxt = '0;
		end else if (ch1_period && holdoff_r != HOLD_MAX) begin
			holdoff_nxt = holdoff_r + HOLD_W'(1);
		end
	end

	always_ff @(posedge clk_sys or posedge reset) begin
		if (reset) begin
			mismatch_r <= '0;
			holdoff_r <= '1;
			realign_r <= 1'b0;
		end else begin
			mismatch_r <= mismatch_nxt;
			holdoff_r <= holdoff_nxt;
			realign_r <= realign_go;
		end
	end

	////////////////////////////////////////////////////////////////////////////
	// Channel-2 zero-current detect delays.
	logic aux_above_d_r;
	// aux feedback falls below the threshold
	wire logic aux_fall = ch2_active && aux_above_d_r && !aux_above;
	wire logic aux_rise = ch2_active && !aux_above_d_r && aux_above;

	always_ff @(posedge clk_sys or posedge reset) begin
		if (reset) begin
			aux_above_d_r <= 1'b0;
		end else begin
			aux_above_d_r <= aux_above;
		end
	end

	pra_det_delay #(
		.SEL_W(3),
		.STEP_CYC(`PRA_STEP_CYC),
		.CNT_W(DLY_CNT_W)
	) u_rise_delay (
		.clk_sys(clk_sys),
		.reset(reset),
		.trig(aux_rise),
		.sel(ch2_rising_detect_delay),
		.fire_r(ch2_rise_det)
	);

	pra_det_delay #(
		.SEL_W(3),
		.STEP_CYC(`PRA_STEP_CYC),
		.CNT_W(DLY_CNT_W)
	) u_fall_delay (
		.clk_sys(clk_sys),
		.reset(reset),
		.trig(aux_fall),
		.sel(ch2_falling_detect_delay),
		.fire_r(ch2_fall_det)
	);

	////////////////////////////////////////////////////////////////////////////
	// Protection enables are held in their own flops so they follow the register one cycle later.
	logic short_protect_en_r;
	logic voltage_difference_fault_cfg_fault_en_r;

	always_ff @(posedge clk_sys or posedge reset) begin
		if (reset) begin
			short_protect_en_r <= 1'b0;
			voltage_difference_fault_cfg_fault_en_r <= 1'b0;
		end else begin
			short_protect_en_r <= !short_protect_disable;
			voltage_difference_fault_cfg_fault_en_r <= !voltage_difference_fault_cfg;
		end
	end

	////////////////////////////////////////////////////////////////////////////
	// Read port: data stand only in the cycle after the strobe; unmapped reads return zero.
	wire pra_pkg::pra_byte_t enable_view = 8'(phase_realign_enable_r) << `PRA_ENABLE_BIT;
	wire pra_pkg::pra_byte_t stat_mis_view = 8'(mismatch_r);
	wire pra_pkg::pra_byte_t stat_hold_view = (8'(holdoff_ok) << `PRA_STAT_HOLD_OK_BIT) | 8'(holdoff_r);

	always_comb begin
		rdata_nxt = '0;
		if (rd_en) begin
			if (sel_thresh) begin
				rdata_nxt = phase_realign_thresholds_r;
			end else if (sel_delay) begin
				rdata_nxt = ch2_detect_delay_protect_r;
			end else if (sel_enable) begin
				rdata_nxt = enable_view;
			end else if (sel_stat_mis) begin
				rdata_nxt = stat_mis_view;
			end else if (sel_stat_hold) begin
				rdata_nxt = stat_hold_view;
			end
		end
	end

	always_ff @(posedge clk_sys or posedge reset) begin
		if (reset) begin
			rdata_r <= '0;
		end else begin
			rdata_r <= rdata_nxt;
		end
	end

	assign rdata = rdata_r;
	assign realign_pulse = realign_r;
	assign short_protect_en = short_protect_en_r;
	assign voltage_difference_fault_cfg_fault_en = voltage_difference_fault_cfg_fault_en_r;

	////////////////////////////////////////////////////////////////////////////
	default clocking top_cb @(posedge clk_sys); endclocking
	default disable iff (reset);

	sequence s_up_step;
		!realign_go && wrong_id && mismatch_r != MIS_MAX;
	endsequence

	sequence s_down_step;
		!realign_go && right_id && mismatch_r >= MIS_W'(2);
	endsequence

	sequence s_hold_step;
		!realign_go && ch1_period && holdoff_r != HOLD_MAX;
	endsequence

	holdoff_gate_a: assert property (realign_pulse |-> $past(holdoff_r) >= $past(realign_holdoff_count))
		else $error("realignment issued before the hold-off elapsed");
	holdoff_restart_a: assert property (realign_go && realign_holdoff_count != '0 |=> !realign_go)
		else $error("second realignment inside the hold-off window");
	trip_gate_a: assert property (realign_pulse |-> $past(mismatch_r) > MIS_W'($past(mismatch_trip_threshold)))
		else $error("realignment issued without exceeding the trip threshold");
	count_up_a: assert property (s_up_step |=> mismatch_r == $past(mismatch_r) + MIS_W'(1))
		else $error("mismatch counter did not add one");
	count_down_a: assert property (s_down_step |=> mismatch_r == $past(mismatch_r) - MIS_W'(2))
		else $error("mismatch counter did not subtract two");
	realign_fire_a: assert property (phase_realign_enable_r && trip_over && holdoff_ok |=> realign_pulse)
		else $error("realignment conditions met but no pulse");
	enable_gate_a: assert property (!phase_realign_enable_r |=> !realign_pulse)
		else $error("realignment while disabled");
	floor_zero_a: assert property (!realign_go && right_id && mismatch_r < MIS_W'(2) |=> mismatch_r == '0)
		else $error("mismatch counter did not floor at zero");
	clear_after_a: assert property (realign_go |=> mismatch_r == '0 && holdoff_r == '0 && realign_pulse)
		else $error("counter not cleared after realignment");
	scp_follow_a: assert property (wr_delay |=> ##1 short_protect_en == !$past(wdata[`PRA_SCP_BIT], 2))
		else $error("short protection enable does not follow its bit");
	voltage_difference_fault_cfg_follow_a: assert property (wr_delay |=> ##1 voltage_difference_fault_cfg_fault_en == !$past(wdata[`PRA_VOLTAGE_DIFFERENCE_FAULT_CFG_BIT], 2))
		else $error("voltage difference fault enable does not follow its bit");
	holdoff_step_a: assert property (s_hold_step |=> holdoff_r == $past(holdoff_r) + HOLD_W'(1))
		else $error("hold-off count did not advance on a channel-1 period");
	// Read data stand one cycle.
	read_idle_a: assert property (!rd_en |=> rdata == '0)
		else $error("read data did not return to zero after a read");

endmodule // pra_top
`default_nettype wire

// ---- verif/pra_top_bench.sv ----
// Self-checking bench for the phase realign supervisor and channel-2 detect delay configuration.
`timescale 1ns/1ps
`default_nettype none
`include "pra_map.svh"
module pra_top_bench;
	logic clk_sys, reset, wr_en, rd_en, ch1_period, s2_period, s2_id_ok, ch2_active, aux_above;
	logic [7:0] addr, wdata;
	wire logic [7:0] rdata;
	wire logic realign_pulse, ch2_rise_det, ch2_fall_det, short_protect_en, voltage_difference_fault_cfg_fault_en;
	int miscompares = 0;
	int checked = 0;
	int pulses = 0;

	pra_top u_pra_top (.clk_sys(clk_sys), .reset(reset), .addr(addr), .wdata(wdata), .wr_en(wr_en),
		.rd_en(rd_en), .rdata(rdata), .ch1_period(ch1_period), .s2_period(s2_period), .s2_id_ok(s2_id_ok),
		.ch2_active(ch2_active), .aux_above(aux_above), .realign_pulse(realign_pulse),
		.ch2_rise_det(ch2_rise_det), .ch2_fall_det(ch2_fall_det), .short_protect_en(short_protect_en),
		.voltage_difference_fault_cfg_fault_en(voltage_difference_fault_cfg_fault_en));

	initial begin
		clk_sys = 1'b0;
		forever #2.5 clk_sys = ~clk_sys;
	end

	// Counting every high cycle also exposes a pulse that stands longer than one cycle.
	always @(posedge clk_sys) begin
		if (realign_pulse === 1'b1) begin
			pulses <= pulses + 1;
		end
	end

	////////////////////////////////////////////////////////////////////////////
	task automatic check8(input string what, input logic [7:0] exp, input logic [7:0] got);
		checked++;
		if (got !== exp) begin
			miscompares++;
			$display("mismatch %s expected %h seen %h", what, exp, got);
		end
	endtask

	task automatic reg_write(input logic [7:0] a, input logic [7:0] d);
		@(posedge clk_sys);
		wr_en <= 1'b1;
		addr <= a;
		wdata <= d;
		@(posedge clk_sys);
		wr_en <= 1'b0;
	endtask

	task automatic check_reg(input string what, input logic [7:0] a, input logic [7:0] exp);
		@(posedge clk_sys);
		rd_en <= 1'b1;
		addr <= a;
		@(posedge clk_sys);
		rd_en <= 1'b0;
		#1;
		check8(what, exp, rdata);
	endtask

	task automatic period_step(input logic is_ch1, input logic ok);
		@(posedge clk_sys);
		if (is_ch1) begin
			ch1_period <= 1'b1;
		end else begin
			s2_period <= 1'b1;
		end
		s2_id_ok <= ok;
		@(posedge clk_sys);
		ch1_period <= 1'b0;
		s2_period <= 1'b0;
	endtask

	task automatic wrong_steps(input int n);
		repeat (n) period_step(1'b0, 1'b0);
		repeat (4) @(posedge clk_sys);
	endtask

	// Toggles the aux level and counts edges until the selected detect pulse shows, at most 100.
	task automatic delay_case(input logic rise, input logic active, input int exp_n);
		int n;
		@(posedge clk_sys);
		ch2_active <= active;
		aux_above <= rise;
		n = 0;
		while (n < 100) begin
			@(posedge clk_sys);
			n++;
			#1;
			if ((rise ? ch2_rise_det : ch2_fall_det) === 1'b1) begin
				break;
			end
		end
		check8(rise ? "rise delay" : "fall delay", 8'(exp_n), 8'(n));
	endtask

	task report_and_stop;
		$display("comparisons %0d mismatches %0d", checked, miscompares);
		if (miscompares == 0 && checked > 0) begin
			$display("Run complete: PASS");
		end else begin
			$display("Run complete: FAIL");
		end
		$finish;
	endtask

	////////////////////////////////////////////////////////////////////////////
	initial begin
		repeat (20000) @(posedge clk_sys);
		miscompares++;
		report_and_stop();
	end

	initial begin
		{reset, wr_en, rd_en, ch1_period, s2_period, s2_id_ok, ch2_active, aux_above} = 8'h80;
		addr = 8'h00;
		wdata = 8'h00;
		repeat (8) @(posedge clk_sys);
		reset <= 1'b0;
		repeat (2) @(posedge clk_sys);
		check_reg("thresholds", `PRA_OFS_THRESH, 8'h00);
		check_reg("delay", `PRA_OFS_DELAY, 8'h00);
		check_reg("enable", `PRA_OFS_ENABLE, 8'h00);
		check_reg("hold-off status", `PRA_OFS_STAT_HOLD, 8'h8f);
		check8("protect enables", 8'h03, {6'h00, short_protect_en, voltage_difference_fault_cfg_fault_en});
		reg_write(`PRA_OFS_THRESH, 8'ha5);
		check_reg("thresholds", `PRA_OFS_THRESH, 8'ha5);
		reg_write(`PRA_OFS_ENABLE, 8'hff);
		check_reg("enable", `PRA_OFS_ENABLE, 8'h40);
		reg_write(`PRA_OFS_STAT_MIS, 8'hff);
		check_reg("mismatch status", `PRA_OFS_STAT_MIS, 8'h00);
		check_reg("unmapped", 8'h7e, 8'h00);
		$display("test registers done");
		for (int i = 0; i < 4; i++) begin
			reg_write(`PRA_OFS_DELAY, 8'(i));
			repeat (2) @(posedge clk_sys);
			check8("protect enables", 8'(3 - i), {6'h00, short_protect_en, voltage_difference_fault_cfg_fault_en});
		end
		$display("test protection done");
		reg_write(`PRA_OFS_THRESH, 8'h02);
		reg_write(`PRA_OFS_ENABLE, 8'h00);
		wrong_steps(4);
		check8("pulses while disabled", 8'h00, 8'(pulses));
		check_reg("mismatch count", `PRA_OFS_STAT_MIS, 8'h04);
		period_step(1'b0, 1'b1);
		check_reg("mismatch count", `PRA_OFS_STAT_MIS, 8'h02);
		period_step(1'b0, 1'b1);
		period_step(1'b0, 1'b1);
		check_reg("mismatch floor", `PRA_OFS_STAT_MIS, 8'h00);
		// The enable must be set before the supervisor may act.
		reg_write(`PRA_OFS_ENABLE, 8'h40);
		wrong_steps(2);
		check8("pulses at trip", 8'h00, 8'(pulses));
		wrong_steps(1);
		check8("pulses over trip", 8'h01, 8'(pulses));
		check_reg("mismatch cleared", `PRA_OFS_STAT_MIS, 8'h00);
		$display("test mismatch done");
		reg_write(`PRA_OFS_THRESH, 8'h32);
		wrong_steps(3);
		repeat (2) period_step(1'b1, 1'b1);
		check_reg("hold-off status", `PRA_OFS_STAT_HOLD, 8'h02);
		repeat (4) @(posedge clk_sys);
		check8("pulses in hold-off", 8'h01, 8'(pulses));
		period_step(1'b1, 1'b1);
		repeat (4) @(posedge clk_sys);
		check8("pulses after hold-off", 8'h02, 8'(pulses));
		$display("test hold-off done");
		// A level change seen at one edge triggers there; a zero setting shows the pulse after that edge.
		delay_case(1'b1, 1'b1, 1);
		delay_case(1'b0, 1'b1, 1);
		reg_write(`PRA_OFS_DELAY, 8'h5c);
		delay_case(1'b1, 1'b1, 21);
		delay_case(1'b0, 1'b1, 71);
		delay_case(1'b1, 1'b0, 100);
		delay_case(1'b0, 1'b0, 100);
		$display("test detect delays done");
		report_and_stop();
	end
endmodule // pra_top_bench
`default_nettype wire
